// *** hdl/pccl_core.sv ***
// Carrier sense, collision, link monitor and loopback control core
// Notes on behaviour
// - Carrier on crs in MII, crs_dv in RMII
// - Repeater or full duplex: receive-only carrier
// - Two non-adjacent zeros in ten bits start carrier
// - Ten ones before start delimiter ends carrier
// - After start delimiter, hold until T/R or IDLE pair
// - T without R, or lone IDLE, drops carrier until the next data symbol
// - Collision while transmit and receive overlap
// - Collision output asynchronous; MAC must synchronise
// - No collision in full duplex unless test set
// - Collision test follows transmit enable quickly
// - Combined link status drives status and indicator
// - Line valid: ready, await negotiation, then up
// - Negotiation disabled: straight to link up
// - Wait 330 ms before link ready
// - Line valid drop: link down at once
// - 10BASE-T mode: link from 10BASE-T receiver
// - Near loopback routes transmit data to receive outputs
// - Near loopback: no collision unless test set
// - Near loopback: line transmitters powered down
// - Far loopback returns line data, isolates MAC
// - Far loopback only in RMII mode
// - Extended registers reached only indirectly
`timescale 1ns/1ns
`include "pccl_cfg.svh"
module pccl_core
    import pccl_pkg::*;
#(
    parameter int STAB_CYC = `PCCL_STAB_CYC,
    parameter int DW       = 4
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    // Register port
    input  wire logic [3:0]    reg_addr,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [15:0]   reg_rdata,
    // MAC transmit side (pins)
    input  wire logic          tx_clk,
    input  wire logic          tx_en,
    input  wire logic [DW-1:0] tx_data,
    // MAC receive side
    output logic               crs,
    output logic               crs_dv,
    output logic               col,
    output logic [DW-1:0]      rx_data,
    output logic               rx_dv,
    // Line side: coded receive bits from the media, data to media
    input  wire logic          line_bit,
    input  wire logic          line_bit_valid,
    input  wire logic [DW-1:0] line_rx_data,
    input  wire logic          line_rx_dv,
    output logic [DW-1:0]      line_tx_data,
    output logic               line_tx_en,
    output logic               line_tx_power,
    // Analogue and peer status
    input  wire logic          line_valid,
    input  wire logic          aneg_enable,
    input  wire logic          ten_mode,
    input  wire logic          ten_link,
    // Indicator
    output logic               first_indicator_output
);
    logic [4:0]  s_in;
    logic [4:0]  s_sync;
    logic [4:0]  s_rise;
    logic        txc_s;
    logic        tx_s;
    logic        lbit;
    logic        lbit_v;
    logic        lvalid;

    // Slow pin inputs go through one shared synchroniser
    assign s_in = {line_valid, line_bit_valid, line_bit, tx_en, tx_clk};
    pccl_sync #(.W(5)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (s_in),
        .sync_out (s_sync),
        .rise     (s_rise),
        .fall     ()
    );
    assign txc_s          = s_sync[0];
    assign tx_s           = s_sync[1];
    assign lbit           = s_sync[2];
    assign lbit_v         = s_rise[3];
    assign lvalid         = s_sync[4];

    // Control registers
    logic [15:0] ctrl;
    logic [15:0] mode;
    logic [15:0] ext_ctrl;
    logic [15:0] ext_mem [`PCCL_EXT_DEPTH];
    logic        loop_near;
    logic        loop_far;
    logic        aneg_on;
    logic        fdx;
    logic        coltest;
    logic        rmii;
    logic        repeater;

    assign loop_near = ctrl[`PCCL_CTRL_LOOP];
    assign aneg_on   = ctrl[`PCCL_CTRL_ANEG];
    assign fdx       = ctrl[`PCCL_CTRL_FDX];
    assign coltest   = ctrl[`PCCL_CTRL_COLTEST];
    assign rmii      = mode[`PCCL_MODE_RMII];
    assign repeater  = mode[`PCCL_MODE_REPEATER];
    assign loop_far  = mode[`PCCL_MODE_FARLOOP] & rmii;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl     <= `PCCL_CTRL_RESET;
            mode     <= `PCCL_MODE_RESET;
            ext_ctrl <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                `PCCL_REG_CTRL:     ctrl     <= reg_wdata;
                `PCCL_REG_MODE:     mode     <= reg_wdata;
                `PCCL_REG_EXT_CTRL: ext_ctrl <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Extended space: only through the control/data pair
    always_ff @(posedge core_clk) begin
        if (reg_wr && reg_addr == `PCCL_REG_EXT_DATA) begin
            ext_mem[ext_ctrl[3:0]] <= reg_wdata;
        end
    end

    // Carrier detection on the coded bit stream
    pccl_cs_t    cs_state;
    logic [9:0]  win;
    logic [9:0]  next_win;
    logic [3:0]  ones_cnt;
    logic [4:0]  sym_sr;
    logic [2:0]  sym_cnt;
    logic [4:0]  prev_sym;
    logic        rx_carrier;
    logic        zero_pair;

    assign next_win = {win[8:0], lbit};

    // Two zeros with at least one bit of any value between them somewhere in the window
    always_comb begin
        zero_pair = 1'b0;
        for (int i = 0; i < `PCCL_CARR_WIN; i++) begin
            for (int j = i + 2; j < `PCCL_CARR_WIN; j++) begin
                if (!next_win[i] && !next_win[j]) begin
                    zero_pair = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            win <= 10'h3ff;
        end else if (lbit_v) begin
            win <= next_win;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cs_state   <= PCCL_CS_IDLE;
            rx_carrier <= 1'b0;
            ones_cnt   <= 4'h0;
            sym_sr     <= 5'h00;
            sym_cnt    <= 3'h0;
            prev_sym   <= `PCCL_SYM_IDLE;
        end else if (lbit_v) begin
            sym_sr  <= {sym_sr[3:0], lbit};
            sym_cnt <= (sym_cnt == 3'h4) ? 3'h0 : sym_cnt + 3'h1;
            case (cs_state)
                PCCL_CS_IDLE: begin
                    if (zero_pair) begin
                        cs_state   <= PCCL_CS_PRE;
                        rx_carrier <= 1'b1;
                        ones_cnt   <= 4'h0;
                        sym_cnt    <= 3'h0;
                    end
                end
                PCCL_CS_PRE: begin
                    ones_cnt <= lbit ? ones_cnt + 4'h1 : 4'h0;
                    if (lbit && ones_cnt == 4'(`PCCL_ONES_LIMIT - 1)) begin
                        cs_state   <= PCCL_CS_IDLE;
                        rx_carrier <= 1'b0;
                    end else if (sym_cnt == 3'h4) begin
                        // Symbol boundary: J then K opens the stream
                        if (prev_sym == `PCCL_SYM_J && {sym_sr[3:0], lbit} == `PCCL_SYM_K)
                        begin
                            cs_state <= PCCL_CS_STREAM;
                        end
                        prev_sym <= {sym_sr[3:0], lbit};
                    end
                end
                PCCL_CS_STREAM: begin
                    if (sym_cnt == 3'h4) begin
                        prev_sym <= {sym_sr[3:0], lbit};
                        // Closing pair seen; carrier already dropped after first
                        if ((prev_sym == `PCCL_SYM_T && {sym_sr[3:0], lbit} == `PCCL_SYM_R)
                            || (prev_sym == `PCCL_SYM_IDLE
                                && {sym_sr[3:0], lbit} == `PCCL_SYM_IDLE)) begin
                            cs_state   <= PCCL_CS_IDLE;
                            rx_carrier <= 1'b0;
                        end else if ({sym_sr[3:0], lbit} == `PCCL_SYM_T
                                     || {sym_sr[3:0], lbit} == `PCCL_SYM_IDLE) begin
                            rx_carrier <= 1'b0;
                        end else begin
                            rx_carrier <= 1'b1;
                        end
                    end
                end
                default: cs_state <= PCCL_CS_IDLE;
            endcase
        end
    end

    // Receive activity: line carrier, or looped transmit in near loopback
    logic rx_act;
    logic tx_act;
    logic carrier;
    // Stream state alone is no activity: carrier drops on a lone T or IDLE
    assign rx_act  = loop_near ? tx_s : rx_carrier;
    assign tx_act  = tx_s & ~loop_far;
    assign carrier = (repeater || fdx) ? rx_act : (rx_act | tx_act);

    // Collision; registered on the core clock, unrelated to MAC clocks
    logic next_col;
    always_comb begin
        if (loop_far) begin
            next_col = 1'b0;
        end else if (coltest) begin
            next_col = tx_s;
        end else if (fdx || loop_near) begin
            next_col = 1'b0;
        end else begin
            next_col = tx_act & rx_act;
        end
    end

    // Link monitor
    pccl_link_t  lm_state;
    logic [31:0] stab_cnt;
    logic        link100;
    logic        link;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lm_state <= PCCL_LINK_DOWN;
            stab_cnt <= 32'h0;
        end else if (!lvalid) begin
            lm_state <= PCCL_LINK_DOWN;
            stab_cnt <= 32'h0;
        end else begin
            case (lm_state)
                PCCL_LINK_DOWN: begin
                    lm_state <= PCCL_LINK_WAIT;
                    stab_cnt <= 32'h1;
                end
                PCCL_LINK_WAIT: begin
                    if (!aneg_on) begin
                        lm_state <= PCCL_LINK_UP;
                    end else if (stab_cnt >= 32'(STAB_CYC)) begin
                        lm_state <= PCCL_LINK_READY;
                    end else begin
                        stab_cnt <= stab_cnt + 32'h1;
                    end
                end
                PCCL_LINK_READY: begin
                    if (aneg_enable) begin
                        lm_state <= PCCL_LINK_UP;
                    end
                end
                PCCL_LINK_UP: ;
                default: lm_state <= PCCL_LINK_DOWN;
            endcase
        end
    end

    assign link100 = (lm_state == PCCL_LINK_UP) & lvalid;
    assign link    = ten_mode ? ten_link : link100;

    // MAC facing outputs and line drive
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            crs                    <= 1'b0;
            crs_dv                 <= 1'b0;
            col                    <= 1'b0;
            rx_data                <= '0;
            rx_dv                  <= 1'b0;
            line_tx_data           <= '0;
            line_tx_en             <= 1'b0;
            line_tx_power          <= 1'b0;
            first_indicator_output <= 1'b0;
        end else begin
            // Far loopback leaves the MAC pins quiet
            crs    <= ~loop_far & ~rmii & carrier;
            crs_dv <= ~loop_far & rmii & carrier;
            col    <= next_col;
            if (loop_near) begin
                rx_data <= tx_data;
                rx_dv   <= tx_s;
            end else if (loop_far) begin
                rx_data <= '0;
                rx_dv   <= 1'b0;
            end else begin
                rx_data <= line_rx_data;
                rx_dv   <= line_rx_dv;
            end
            if (loop_far) begin
                line_tx_data <= line_rx_data;
                line_tx_en   <= line_rx_dv;
            end else begin
                line_tx_data <= tx_data;
                line_tx_en   <= tx_s & ~loop_near;
            end
            line_tx_power          <= ~loop_near;
            first_indicator_output <= link;
        end
    end

    // Register reads, one cycle later
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `PCCL_REG_CTRL:     reg_rdata <= ctrl;
                `PCCL_REG_MODE:     reg_rdata <= mode;
                `PCCL_REG_STATUS:   reg_rdata <= {13'h0, link, col, crs | crs_dv};
                `PCCL_REG_EXT_CTRL: reg_rdata <= ext_ctrl;
                `PCCL_REG_EXT_DATA: reg_rdata <= ext_mem[ext_ctrl[3:0]];
                default:            reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

// *** hdl/pccl_sync.sv ***
// Two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ns
module pccl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Asynchronous in, synchronised out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta;
    logic [W-1:0] prev;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta     <= '0;
            sync_out <= '0;
            prev     <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
            prev     <= sync_out;
        end
    end

    assign rise = sync_out & ~prev;
    assign fall = ~sync_out & prev;
endmodule

// *** inc/pccl_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the status/test core
`ifndef PCCL_CFG_SVH
`define PCCL_CFG_SVH

// Register indices
`define PCCL_REG_CTRL        4'h0
`define PCCL_REG_MODE        4'h1
`define PCCL_REG_STATUS      4'h2
`define PCCL_REG_EXT_CTRL    4'h3
`define PCCL_REG_EXT_DATA    4'h4
// Control fields
`define PCCL_CTRL_LOOP       14
`define PCCL_CTRL_ANEG       12
`define PCCL_CTRL_FDX        8
`define PCCL_CTRL_COLTEST    7
`define PCCL_CTRL_RESET      16'h1000
// Mode fields
`define PCCL_MODE_FARLOOP    9
`define PCCL_MODE_RMII       1
`define PCCL_MODE_REPEATER   0
`define PCCL_MODE_RESET      16'h0000
// Status fields
`define PCCL_STAT_LINK       2
`define PCCL_STAT_COL        1
`define PCCL_STAT_CRS        0
// Symbol codes (5-bit)
`define PCCL_SYM_J           5'h18
`define PCCL_SYM_K           5'h11
`define PCCL_SYM_T           5'h0d
`define PCCL_SYM_R           5'h07
`define PCCL_SYM_IDLE        5'h1f
// Timing
`define PCCL_CLK_HZ          10000000
`define PCCL_STAB_MS         330
// Divide first: the plain product would overflow a 32-bit int
`define PCCL_STAB_CYC        (`PCCL_STAB_MS * (`PCCL_CLK_HZ / 1000))
`define PCCL_CARR_WIN        10
`define PCCL_ONES_LIMIT      10
`define PCCL_EXT_DEPTH       16

`endif

// *** inc/pccl_pkg.sv ***
// Types shared by the status/test core
package pccl_pkg;
    typedef enum logic [1:0] {
        PCCL_LINK_DOWN,
        PCCL_LINK_WAIT,
        PCCL_LINK_READY,
        PCCL_LINK_UP
    } pccl_link_t;
    typedef enum logic [1:0] {
        PCCL_CS_IDLE,
        PCCL_CS_PRE,
        PCCL_CS_STREAM
    } pccl_cs_t;
endpackage

// *** test/pccl_mac_model.sv ***
// MAC transmit model with its own link clock, running only in frames
`timescale 1ns/1ns
module pccl_mac_model (
    // Bench control and collision back from the device
    input  wire logic go,
    input  wire logic col,
    // MII transmit pins, and collision as synchronised to tx_clk
    output logic       tx_clk,
    output logic       tx_en,
    output logic [3:0] tx_data,
    output logic       col_seen
);
    logic [1:0] col_sync;
    initial begin
        tx_clk = 1'b0;
        tx_en = 1'b0;
        tx_data = 4'h0;
        col_sync = 2'h0;
    end
    always begin
        wait (go || tx_en);
        #400 tx_clk = ~tx_clk;
    end
    // Released data lines toggle so stale values are never trusted
    always @(posedge tx_clk) begin
        tx_en <= go;
        tx_data <= go ? tx_data + 4'h1 : ~tx_data;
    end
    always @(posedge tx_clk)
        col_sync <= {col_sync[0], col};
    assign col_seen = col_sync[1];
endmodule

// *** test/pccl_monitor.sv ***
// Port-level assertions for the carrier, collision and link core
`timescale 1ns/1ns
`include "pccl_cfg.svh"
module pccl_monitor (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Register writes
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    // Pins
    input wire logic        tx_en,
    input wire logic        line_valid,
    input wire logic        ten_mode,
    input wire logic        ten_link,
    input wire logic        crs,
    input wire logic        crs_dv,
    input wire logic        col,
    input wire logic        line_tx_en,
    input wire logic        line_tx_power,
    input wire logic        first_indicator_output
);
    // Shadow control words, rebuilt from the writes
    logic [15:0] ctrl;
    logic [15:0] mode;
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            ctrl <= `PCCL_CTRL_RESET;
        else if (reg_wr && reg_addr == `PCCL_REG_CTRL)
            ctrl <= reg_wdata;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            mode <= `PCCL_MODE_RESET;
        else if (reg_wr && reg_addr == `PCCL_REG_MODE)
            mode <= reg_wdata;
    end
    wire fdx  = ctrl[`PCCL_CTRL_FDX];
    wire near = ctrl[`PCCL_CTRL_LOOP];
    wire colt = ctrl[`PCCL_CTRL_COLTEST];
    wire rmii = mode[`PCCL_MODE_RMII];
    wire far  = mode[`PCCL_MODE_FARLOOP] && rmii;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Three cycles of a setting let the registered outputs catch up
    sequence s_fdx_held; (fdx && !colt)[*3]; endsequence
    sequence s_near_held; (near && !colt)[*3]; endsequence
    sequence s_far_held; (far && !colt)[*3]; endsequence
    sequence s_ten_held; (ten_mode && $stable(ten_link))[*3]; endsequence
    a_fdx_no_col: assert property (s_fdx_held |-> !col)
        else $error("collision in full duplex");
    a_near_no_col: assert property (s_near_held |-> !col)
        else $error("collision in near loopback");
    a_near_tx_off: assert property (near[*3] |-> !line_tx_power && !line_tx_en)
        else $error("line transmitter active in near loopback");
    a_far_quiet: assert property (s_far_held |-> !col && !crs && !crs_dv)
        else $error("MAC side not isolated in far loopback");
    a_mii_pin: assert property ((!rmii)[*3] |-> !crs_dv)
        else $error("crs_dv driven in MII mode");
    a_rmii_pin: assert property (rmii[*3] |-> !crs)
        else $error("crs driven in RMII mode");
    a_link_drop: assert property ((!line_valid && !ten_mode)[*6] |-> !first_indicator_output)
        else $error("link indicator stays up without line valid");
    a_ten_link: assert property (s_ten_held |-> first_indicator_output == ten_link)
        else $error("indicator not following 10 Mbps link");
    a_coltest_on: assert property (colt && !far && $rose(tx_en) |-> ##[1:51] col)
        else $error("collision test too slow to assert");
    a_coltest_off: assert property (colt && $fell(tx_en) |-> ##[1:6] !col)
        else $error("collision test too slow to release");
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the carrier, collision and link core
`timescale 1ns/1ns
`include "pccl_cfg.svh"
module tb_top;
    localparam int STAB = 20;
    localparam int LIMIT = 20000;
    typedef struct packed {logic w; logic [3:0] a; logic [15:0] d; logic [15:0] e;} pccl_rrow_t;
    typedef struct packed {logic [15:0] c; logic [15:0] m; logic crs; logic dv;} pccl_crow_t;
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
    logic [3:0] reg_addr = 4'h0, line_rx_data = 4'h0, tx_data, rx_data, line_tx_data;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
    logic line_bit = 1'b1, line_bit_valid = 1'b0, line_rx_dv = 1'b0, line_valid = 1'b0;
    logic aneg_enable = 1'b0, ten_mode = 1'b0, ten_link = 1'b0;
    logic tx_clk, tx_en, crs, crs_dv, col, rx_dv, line_tx_en, line_tx_power;
    logic first_indicator_output, col_seen;
    int n_fail = 0, compares = 0, cyc = 0;
    pccl_rrow_t regs [11] = '{
        '{0, `PCCL_REG_CTRL, 16'h0, 16'h1000}, '{0, `PCCL_REG_MODE, 16'h0, 16'h0000},
        '{1, `PCCL_REG_CTRL, 16'h1100, 16'h1100}, '{1, `PCCL_REG_MODE, 16'h0203, 16'h0203},
        '{1, `PCCL_REG_STATUS, 16'h0007, 16'h0000}, '{1, 4'hf, 16'hffff, 16'h0000},
        '{1, `PCCL_REG_EXT_CTRL, 16'h0005, 16'h0005}, '{1, `PCCL_REG_EXT_DATA, 16'habcd, 16'habcd},
        '{1, `PCCL_REG_EXT_CTRL, 16'h0006, 16'h0006}, '{1, `PCCL_REG_EXT_DATA, 16'h1234, 16'h1234},
        '{1, `PCCL_REG_EXT_CTRL, 16'h0005, 16'h0005}};
    pccl_crow_t cs [4] = '{'{16'h1000, 16'h0000, 1, 0}, '{16'h1000, 16'h0002, 0, 1},
        '{16'h1100, 16'h0000, 0, 0}, '{16'h1000, 16'h0001, 0, 0}};
    always #50 core_clk = ~core_clk;
    pccl_core #(.STAB_CYC(STAB)) DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .tx_clk, .tx_en, .tx_data, .crs, .crs_dv, .col, .rx_data, .rx_dv,
        .line_bit, .line_bit_valid, .line_rx_data, .line_rx_dv, .line_tx_data, .line_tx_en,
        .line_tx_power, .line_valid, .aneg_enable, .ten_mode, .ten_link, .first_indicator_output);
    pccl_mac_model mac (.go, .col, .tx_clk, .tx_en, .tx_data, .col_seen);
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // A gap cycle after each strobe keeps one assignment per signal per step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic bit1(input logic b);
        line_bit <= b;
        repeat (2) @(posedge core_clk);
        line_bit_valid <= 1'b1;
        repeat (4) @(posedge core_clk);
        line_bit_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic sym(input logic [4:0] s);
        for (int i = 4; i >= 0; i--)
            bit1(s[i]);
    endtask
    // Zeros left by T/R may start a carrier; fifteen ones end it before 0,1,0
    task automatic pre;
        sym(`PCCL_SYM_IDLE);
        sym(`PCCL_SYM_IDLE);
        sym(`PCCL_SYM_IDLE);
        bit1(1'b0);
        bit1(1'b1);
        bit1(1'b0);
    endtask
    task automatic crs_is(input logic e);
        repeat (4) @(posedge core_clk);
        chk("crs", {15'h0, e}, {15'h0, crs});
    endtask
    task automatic frame(input int n);
        go <= 1'b1;
        repeat (n) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        foreach (regs[i]) begin
            if (regs[i].w)
                wr(regs[i].a, regs[i].d);
            rd(regs[i].a, rv);
            chk("register", regs[i].e, rv);
        end
        rd(`PCCL_REG_EXT_DATA, rv);
        chk("indirect data", 16'habcd, rv);
        foreach (cs[i]) begin
            wr(`PCCL_REG_CTRL, cs[i].c);
            wr(`PCCL_REG_MODE, cs[i].m);
            frame(20);
            chk("crs", {15'h0, cs[i].crs}, {15'h0, crs});
            chk("crs_dv", {15'h0, cs[i].dv}, {15'h0, crs_dv});
            go <= 1'b0;
            repeat (20) @(posedge core_clk);
        end
        wr(`PCCL_REG_MODE, 16'h0000);
        pre();
        crs_is(1'b1);
        sym(`PCCL_SYM_IDLE);
        sym(`PCCL_SYM_IDLE);
        crs_is(1'b0);
        pre();
        sym(`PCCL_SYM_J);
        sym(`PCCL_SYM_K);
        sym(5'h1e);
        crs_is(1'b1);
        sym(`PCCL_SYM_T);
        crs_is(1'b0);
        sym(5'h1e);
        crs_is(1'b1);
        sym(`PCCL_SYM_T);
        sym(`PCCL_SYM_R);
        crs_is(1'b0);
        pre();
        sym(`PCCL_SYM_J);
        sym(`PCCL_SYM_K);
        sym(`PCCL_SYM_IDLE);
        crs_is(1'b0);
        sym(5'h1e);
        crs_is(1'b1);
        sym(`PCCL_SYM_IDLE);
        sym(`PCCL_SYM_IDLE);
        crs_is(1'b0);
        // Receive starts, transmit overlaps, then receive ends mid-frame
        pre();
        frame(20);
        chk("col", 16'h0001, {15'h0, col});
        sym(`PCCL_SYM_IDLE);
        sym(`PCCL_SYM_IDLE);
        repeat (4) @(posedge core_clk);
        chk("col", 16'h0000, {15'h0, col});
        go <= 1'b0;
        repeat (20) @(posedge core_clk);
        wr(`PCCL_REG_CTRL, 16'h1180);
        frame(20);
        chk("col", 16'h0001, {15'h0, col});
        repeat (4) @(posedge core_clk);
        chk("col seen", 16'h0001, {15'h0, col_seen});
        go <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk("col", 16'h0000, {15'h0, col});
        wr(`PCCL_REG_CTRL, 16'h5000);
        frame(20);
        @(posedge tx_clk);
        repeat (4) @(posedge core_clk);
        chk("rx_data", {12'h0, tx_data}, {12'h0, rx_data});
        chk("rx_dv", 16'h0001, {15'h0, rx_dv});
        chk("line power", 16'h0000, {15'h0, line_tx_power});
        go <= 1'b0;
        repeat (20) @(posedge core_clk);
        wr(`PCCL_REG_CTRL, 16'h1000);
        wr(`PCCL_REG_MODE, 16'h0202);
        line_rx_data <= 4'ha;
        line_rx_dv <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("line data", 16'h000a, {12'h0, line_tx_data});
        chk("line enable", 16'h0001, {15'h0, line_tx_en});
        wr(`PCCL_REG_MODE, 16'h0200);
        repeat (4) @(posedge core_clk);
        chk("line enable", 16'h0000, {15'h0, line_tx_en});
        line_rx_dv <= 1'b0;
        aneg_enable <= 1'b1;
        line_valid <= 1'b1;
        repeat (STAB / 2) @(posedge core_clk);
        chk("link", 16'h0000, {15'h0, first_indicator_output});
        repeat (STAB) @(posedge core_clk);
        chk("link", 16'h0001, {15'h0, first_indicator_output});
        rd(`PCCL_REG_STATUS, rv);
        chk("status", 16'h0001 << `PCCL_STAT_LINK, rv);
        line_valid <= 1'b0;
        aneg_enable <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("link", 16'h0000, {15'h0, first_indicator_output});
        line_valid <= 1'b1;
        repeat (STAB + 10) @(posedge core_clk);
        chk("link", 16'h0000, {15'h0, first_indicator_output});
        aneg_enable <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("link", 16'h0001, {15'h0, first_indicator_output});
        line_valid <= 1'b0;
        wr(`PCCL_REG_CTRL, 16'h0000);
        repeat (6) @(posedge core_clk);
        line_valid <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("link", 16'h0001, {15'h0, first_indicator_output});
        ten_mode <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("link", 16'h0000, {15'h0, first_indicator_output});
        ten_link <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("link", 16'h0001, {15'h0, first_indicator_output});
        end_of_test();
    end
endmodule
bind pccl_core pccl_monitor mon (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .tx_en,
    .line_valid, .ten_mode, .ten_link, .crs, .crs_dv, .col, .line_tx_en, .line_tx_power,
    .first_indicator_output);
